// ==== pgob_pkg.sv ====
/*
  Shared constants for the protocol and GPIO option byte bank: APB
  offsets, field positions, writable masks, reset values, GPIO mode
  codes and authentication command kinds.
  Assumes a 32-bit APB with byte addresses and one register per word.
*/
package pgob_pkg;

  localparam int GPIO_N = 2;

  // register byte addresses
  localparam logic [7:0] OFFS_OPT_A = 8'h00;
  localparam logic [7:0] OFFS_OPT_B = 8'h04;
  localparam logic [7:0] OFFS_CFG0  = 8'h08;
  localparam logic [7:0] OFFS_CFG1  = 8'h0C;
  localparam logic [7:0] OFFS_FSEL  = 8'h10;
  localparam logic [7:0] OFFS_STAT  = 8'h14;

  // protocol option byte a
  localparam int A_SESS_KEY = 7;
  localparam int A_ECC_UNI  = 2;
  localparam int A_AES_SYM  = 0;
  // protocol option byte b
  localparam int B_SIG_INIT = 4;
  localparam int B_SIG_RESP = 3;
  localparam int B_TUN_VAR  = 2;
  localparam int B_AES256   = 1;
  localparam int B_AES128   = 0;
  // gpio config byte
  localparam int CFG_INIT_LVL = 0;
  localparam int CFG_I2C      = 1;

  // status word field positions
  localparam int ST_LEVEL = 0;
  localparam int ST_OE    = 2;
  localparam int ST_I2C   = 4;
  localparam int ST_GRANT = 6;
  localparam int ST_DENY  = 7;

  // reserved bits are never stored
  localparam logic [7:0] A_WMASK   = 8'h85;
  localparam logic [7:0] B_WMASK   = 8'h1F;
  localparam logic [7:0] CFG_WMASK = 8'h03;

  localparam logic [7:0] A_RST    = 8'h05;
  localparam logic [7:0] B_RST    = 8'h1B;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] FSEL_RST = 8'h00;

  localparam logic [7:0] MODE_OUT_A = 8'h02;
  localparam logic [7:0] MODE_OUT_B = 8'h05;
  localparam logic [7:0] MODE_DSPWR = 8'h04;

  localparam logic [7:0] MSG_HOST_INIT = 8'hA0;
  localparam logic [7:0] MSG_HOST_RESP = 8'hB0;

  typedef enum logic [1:0] {
    CMD_ECC_UNI,
    CMD_AES_FIRST,
    CMD_AES_FOLLOW,
    CMD_SIGMA
  } pgob_cmd_type;

  function automatic logic is_out_mode(input logic [7:0] m);
    return (m == MODE_OUT_A) || (m == MODE_OUT_B);
  endfunction

endpackage

// ==== pgob_auth_gate.sv ====
/*
  Authentication command gate: decides grant or deny for each offered
  command from the protocol option bytes, one cycle after the request.
  Assumes option bytes come straight from the register bank flops.
*/
`timescale 1ns/1ps
module pgob_auth_gate (
  input  logic                  clk_sys,
  input  logic                  arst_n,
  input  logic                  cmdValid,
  input  pgob_pkg::pgob_cmd_type cmdKind,
  input  logic [7:0]            sigmaFirstMsg,
  input  logic [7:0]            optA,
  input  logic [7:0]            optB,
  output logic                  cmdGrant,
  output logic                  cmdDeny
);

  logic allow;
  logic grant_ff;
  logic deny_ff;

  always_comb begin
    case (cmdKind)
      pgob_pkg::CMD_ECC_UNI:    allow = optA[pgob_pkg::A_ECC_UNI];
      pgob_pkg::CMD_AES_FIRST,
      pgob_pkg::CMD_AES_FOLLOW: allow = optA[pgob_pkg::A_AES_SYM];
      pgob_pkg::CMD_SIGMA: begin
        if (sigmaFirstMsg == pgob_pkg::MSG_HOST_INIT) begin
          allow = optB[pgob_pkg::B_SIG_INIT];
        end else if (sigmaFirstMsg == pgob_pkg::MSG_HOST_RESP) begin
          allow = optB[pgob_pkg::B_SIG_RESP];
        end else begin
          allow = 1'b0;
        end
      end
      default: allow = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      grant_ff <= 1'b0;
      deny_ff  <= 1'b0;
    end else begin
      grant_ff <= cmdValid & allow;
      deny_ff  <= cmdValid & ~allow;
    end
  end

  assign cmdGrant = grant_ff;
  assign cmdDeny  = deny_ff;

  ecc_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cmdValid && cmdKind == pgob_pkg::CMD_ECC_UNI
    |=> cmdGrant == $past(optA[pgob_pkg::A_ECC_UNI]) && cmdDeny != cmdGrant)
    else $error("ecc unilateral grant does not follow option bit");

  aes_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cmdValid && (cmdKind == pgob_pkg::CMD_AES_FIRST ||
                 cmdKind == pgob_pkg::CMD_AES_FOLLOW)
    |=> cmdDeny == !$past(optA[pgob_pkg::A_AES_SYM]) && cmdDeny != cmdGrant)
    else $error("aes auth decision does not follow option bit");

  sigma_init_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cmdValid && cmdKind == pgob_pkg::CMD_SIGMA &&
    sigmaFirstMsg == pgob_pkg::MSG_HOST_INIT
    |=> cmdGrant == $past(optB[pgob_pkg::B_SIG_INIT]))
    else $error("host initiator sigma decision wrong");

  sigma_resp_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cmdValid && cmdKind == pgob_pkg::CMD_SIGMA &&
    sigmaFirstMsg == pgob_pkg::MSG_HOST_RESP
    |=> cmdGrant == $past(optB[pgob_pkg::B_SIG_RESP])
        ##1 (!cmdGrant || $past(cmdValid)))
    else $error("host responder sigma decision wrong");

  sigma_grant_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    cmdValid && cmdKind == pgob_pkg::CMD_SIGMA ##1 cmdGrant);

  deny_seen_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    cmdDeny);

endmodule

// ==== pgob_gpio_ch.sv ====
/*
  One GPIO channel: output level and enable for the output modes,
  I2C support flag for downstream-power mode, all else idle.
  Assumes set/clear requests and the power-cycle strobe are pulses.
*/
`timescale 1ns/1ps
module pgob_gpio_ch (
  input  logic       clk_sys,
  input  logic       arst_n,
  input  logic [7:0] modeCode,
  input  logic [7:0] cfgByte,
  input  logic       setReq,
  input  logic       clearReq,
  input  logic       pwrCycleDone,
  output logic       pinLevel,
  output logic       pinOe,
  output logic       i2cEn
);

  logic loadPend_ff;
  logic level_ff;
  logic oe_ff;
  logic i2c_ff;
  logic outMode;

  assign outMode = pgob_pkg::is_out_mode(modeCode);

  // initial level is caught on the first edge after reset release, only if modeCode is then an output mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      loadPend_ff <= 1'b1;
    end else begin
      loadPend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= 1'b0;
    end else if (!outMode) begin
      level_ff <= 1'b0;
    end else if (loadPend_ff || pwrCycleDone) begin
      level_ff <= cfgByte[pgob_pkg::CFG_INIT_LVL];
    end else if (setReq) begin
      level_ff <= 1'b1;
    end else if (clearReq) begin
      level_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oe_ff  <= 1'b0;
      i2c_ff <= 1'b0;
    end else begin
      oe_ff  <= outMode;
      i2c_ff <= (modeCode == pgob_pkg::MODE_DSPWR) &&
                cfgByte[pgob_pkg::CFG_I2C];
    end
  end

  assign pinLevel = level_ff;
  assign pinOe    = oe_ff;
  assign i2cEn    = i2c_ff;

  init_level_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pwrCycleDone && outMode
    |=> pinOe && pinLevel == $past(cfgByte[pgob_pkg::CFG_INIT_LVL]))
    else $error("output pin level not restored from config");

  i2c_support_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    1'b1 |=> i2cEn == ($past(modeCode) == pgob_pkg::MODE_DSPWR &&
                       $past(cfgByte[pgob_pkg::CFG_I2C])))
    else $error("i2c support flag wrong");

  idle_mode_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !outMode && modeCode != pgob_pkg::MODE_DSPWR
    |=> !pinOe && !pinLevel && !i2cEn)
    else $error("config byte acted on in an idle mode");

  restore_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    pwrCycleDone && outMode && cfgByte[pgob_pkg::CFG_INIT_LVL] ##1 pinLevel);

endmodule

// ==== pgob_option_regs.sv ====
/*
  Protocol and GPIO option byte bank with APB slave, command gate and
  two GPIO channels.
  Assumes a single 200 MHz clock, inputs synchronous to it, and an
  APB master that holds each request until pready is seen.
*/
`timescale 1ns/1ps
module pgob_option_regs (
  input  logic                   clk_sys,
  input  logic                   arst_n,
  input  logic                   psel,
  input  logic                   penable,
  input  logic                   pwrite,
  input  logic [7:0]             paddr,
  input  logic [31:0]            pwdata,
  input  logic [3:0]             pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  logic                   cmdValid,
  input  pgob_pkg::pgob_cmd_type cmdKind,
  input  logic [7:0]             sigmaFirstMsg,
  output logic                   cmdGrant,
  output logic                   cmdDeny,
  output logic                   sessionKeyEn,
  output logic                   tunnelVariant,
  output logic                   aes256Offer,
  output logic                   aes128Offer,
  input  logic [1:0]             pinSetReq,
  input  logic [1:0]             pinClearReq,
  input  logic                   pwrCycleDone,
  output logic [1:0]             gpioOut,
  output logic [1:0]             gpioOe,
  output logic [1:0]             gpioI2cEn
);

  logic [7:0]       optA_ff;
  logic [7:0]       optB_ff;
  logic [1:0][7:0]  cfg_ff;
  logic [1:0][7:0]  mode_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic             sessKey_ff;
  logic             tunVar_ff;
  logic             aes256_ff;
  logic             aes128_ff;
  logic             lastGrant_ff;
  logic             lastDeny_ff;
  logic [31:0]      nxt_prdata;
  logic [7:0]       statByte;
  logic             setupPh;
  logic             wrEn;
  logic             grant;
  logic             deny;

  function automatic logic reg_hit(input logic [7:0] a);
    return a == pgob_pkg::OFFS_OPT_A || a == pgob_pkg::OFFS_OPT_B ||
           a == pgob_pkg::OFFS_CFG0  || a == pgob_pkg::OFFS_CFG1  ||
           a == pgob_pkg::OFFS_FSEL  || a == pgob_pkg::OFFS_STAT;
  endfunction

  // write strobes select byte lanes; masked bits stay zero
  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [7:0] wd,
                                            input logic       strb,
                                            input logic [7:0] msk);
    return strb ? (wd & msk) : old;
  endfunction

  assign setupPh = psel && !penable && !pready_ff;
  // writes land only on the access edge with pready seen high
  assign wrEn = psel && penable && pready_ff && pwrite && reg_hit(paddr);

  always_comb begin
    statByte = '0;
    statByte[pgob_pkg::ST_LEVEL +: 2] = gpioOut;
    statByte[pgob_pkg::ST_OE +: 2]    = gpioOe;
    statByte[pgob_pkg::ST_I2C +: 2]   = gpioI2cEn;
    statByte[pgob_pkg::ST_GRANT]      = lastGrant_ff;
    statByte[pgob_pkg::ST_DENY]       = lastDeny_ff;
  end

  always_comb begin
    nxt_prdata = '0;
    case (paddr)
      pgob_pkg::OFFS_OPT_A: nxt_prdata[7:0]  = optA_ff;
      pgob_pkg::OFFS_OPT_B: nxt_prdata[7:0]  = optB_ff;
      pgob_pkg::OFFS_CFG0:  nxt_prdata[7:0]  = cfg_ff[0];
      pgob_pkg::OFFS_CFG1:  nxt_prdata[7:0]  = cfg_ff[1];
      pgob_pkg::OFFS_FSEL:  nxt_prdata[15:0] = mode_ff;
      pgob_pkg::OFFS_STAT:  nxt_prdata[7:0]  = statByte;
      default:              nxt_prdata       = '0;
    endcase
  end

  // zero-wait slave: answer prepared in setup, pready in first access
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (setupPh) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !reg_hit(paddr);
      prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      optA_ff <= pgob_pkg::A_RST;
      optB_ff <= pgob_pkg::B_RST;
    end else if (wrEn) begin
      if (paddr == pgob_pkg::OFFS_OPT_A) begin
        optA_ff <= merge_byte(optA_ff, pwdata[7:0], pstrb[0],
                              pgob_pkg::A_WMASK);
      end
      if (paddr == pgob_pkg::OFFS_OPT_B) begin
        optB_ff <= merge_byte(optB_ff, pwdata[7:0], pstrb[0],
                              pgob_pkg::B_WMASK);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff  <= {pgob_pkg::CFG_RST, pgob_pkg::CFG_RST};
      mode_ff <= {pgob_pkg::FSEL_RST, pgob_pkg::FSEL_RST};
    end else if (wrEn) begin
      if (paddr == pgob_pkg::OFFS_CFG0) begin
        cfg_ff[0] <= merge_byte(cfg_ff[0], pwdata[7:0], pstrb[0],
                                pgob_pkg::CFG_WMASK);
      end
      if (paddr == pgob_pkg::OFFS_CFG1) begin
        cfg_ff[1] <= merge_byte(cfg_ff[1], pwdata[7:0], pstrb[0],
                                pgob_pkg::CFG_WMASK);
      end
      if (paddr == pgob_pkg::OFFS_FSEL) begin
        mode_ff[0] <= merge_byte(mode_ff[0], pwdata[7:0], pstrb[0],
                                 8'hFF);
        mode_ff[1] <= merge_byte(mode_ff[1], pwdata[15:8], pstrb[1],
                                 8'hFF);
      end
    end
  end

  // protocol features handed to the crypto engine
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sessKey_ff <= 1'b0;
      tunVar_ff  <= 1'b0;
      aes256_ff  <= 1'b0;
      aes128_ff  <= 1'b0;
    end else begin
      sessKey_ff <= optA_ff[pgob_pkg::A_SESS_KEY];
      tunVar_ff  <= optB_ff[pgob_pkg::B_TUN_VAR];
      aes256_ff  <= optB_ff[pgob_pkg::B_AES256];
      aes128_ff  <= optB_ff[pgob_pkg::B_AES128];
    end
  end

  // last decision is held for software until the next one
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lastGrant_ff <= 1'b0;
      lastDeny_ff  <= 1'b0;
    end else if (grant || deny) begin
      lastGrant_ff <= grant;
      lastDeny_ff  <= deny;
    end
  end

  pgob_auth_gate u_gate (
    .clk_sys       (clk_sys),
    .arst_n        (arst_n),
    .cmdValid      (cmdValid),
    .cmdKind       (cmdKind),
    .sigmaFirstMsg (sigmaFirstMsg),
    .optA          (optA_ff),
    .optB          (optB_ff),
    .cmdGrant      (grant),
    .cmdDeny       (deny)
  );

  for (genvar g = 0; g < pgob_pkg::GPIO_N; g++) begin : gen_gpio
    pgob_gpio_ch u_ch (
      .clk_sys      (clk_sys),
      .arst_n       (arst_n),
      .modeCode     (mode_ff[g]),
      .cfgByte      (cfg_ff[g]),
      .setReq       (pinSetReq[g]),
      .clearReq     (pinClearReq[g]),
      .pwrCycleDone (pwrCycleDone),
      .pinLevel     (gpioOut[g]),
      .pinOe        (gpioOe[g]),
      .i2cEn        (gpioI2cEn[g])
    );
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign cmdGrant      = grant;
  assign cmdDeny       = deny;
  assign sessionKeyEn  = sessKey_ff;
  assign tunnelVariant = tunVar_ff;
  assign aes256Offer   = aes256_ff;
  assign aes128Offer   = aes128_ff;

  sess_key_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wrEn && paddr == pgob_pkg::OFFS_OPT_A && pstrb[0]
    |=> ##1 sessionKeyEn == $past(pwdata[pgob_pkg::A_SESS_KEY], 2))
    else $error("session key enable does not follow written bit");

  tunnel_var_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wrEn && paddr == pgob_pkg::OFFS_OPT_B && pstrb[0]
    |=> ##1 tunnelVariant == $past(pwdata[pgob_pkg::B_TUN_VAR], 2))
    else $error("tunnel variant does not follow written bit");

  aes256_offer_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    aes256Offer |-> $past(optB_ff[pgob_pkg::B_AES256]))
    else $error("aes-256 offered while disabled");

  aes128_offer_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    !optB_ff[pgob_pkg::B_AES128] |=> !aes128Offer)
    else $error("aes-128 offered while disabled");

  apb_answer_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    setupPh |=> pready && pslverr == !$past(reg_hit(paddr)) ##1 !pready)
    else $error("apb answer not in the first access cycle");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pready && !pslverr && $past(paddr) == pgob_pkg::OFFS_OPT_A
    |-> (prdata[7:0] & ~pgob_pkg::A_WMASK) == 8'h00)
    else $error("reserved protocol bits read back nonzero");

  apb_error_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    pready && pslverr);

  opt_write_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    wrEn && paddr == pgob_pkg::OFFS_OPT_B ##2 !aes256Offer);

  // the crypto engine must never see both answers for one command
  one_decision_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    !(cmdGrant && cmdDeny))
    else $error("grant and deny raised together");

  sess_key_off_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    !optA_ff[pgob_pkg::A_SESS_KEY] |=> !sessionKeyEn)
    else $error("session key enabled while bit clear");

  aes256_on_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    optB_ff[pgob_pkg::B_AES256] |=> aes256Offer)
    else $error("aes-256 not offered while enabled");

  aes128_on_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    optB_ff[pgob_pkg::B_AES128] |=> aes128Offer)
    else $error("aes-128 not offered while enabled");

  tunnel_follow_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    1'b1 |=> tunnelVariant == $past(optB_ff[pgob_pkg::B_TUN_VAR]))
    else $error("tunnel variant does not follow option bit");

  // reserved bits dropped on the way in, so reads never echo them
  opt_b_store_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    wrEn && paddr == pgob_pkg::OFFS_OPT_B && pstrb[0]
    |=> optB_ff == ($past(pwdata[7:0]) & pgob_pkg::B_WMASK))
    else $error("protocol byte b not stored as written");

  cfg_store_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    wrEn && paddr == pgob_pkg::OFFS_CFG0 && pstrb[0]
    |=> cfg_ff[0] == ($past(pwdata[7:0]) & pgob_pkg::CFG_WMASK))
    else $error("pin config byte not stored as written");

  read_idle_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data shown outside the answer cycle");

  last_decision_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    grant || deny
    |=> lastGrant_ff == $past(grant) && lastDeny_ff == $past(deny))
    else $error("status does not hold the last decision");

  pin_enable_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    1'b1 |=> gpioOe[0] == pgob_pkg::is_out_mode($past(mode_ff[0])) &&
             gpioOe[1] == pgob_pkg::is_out_mode($past(mode_ff[1])))
    else $error("pin enable does not follow function select");

endmodule

// ==== pgob_host_model.sv ====
/*
  Host model: APB master standing in for the host controller that
  writes and reads the option bytes.
  Assumes the slave raises pready some cycles after the setup edge.
*/
`timescale 1ns/1ps
module pgob_host_model (
  input  logic        clk_sys,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
  end

  // caller keeps reserved bits of d at zero
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hF;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released bus must not keep looking valid
    paddr   <= ~a;
    pwdata  <= ~d;
    pstrb   <= 4'h0;
  endtask
endmodule

// ==== tb_top.sv ====
/*
  Testbench for the option byte bank: reset values, protocol gating,
  tunnel offers, GPIO modes and an unmapped APB access.
  Assumes the host model drives the APB side.
*/
`timescale 1ns/1ps
module tb_top;
  logic                   clk_sys, arst_n, psel, penable, pwrite;
  logic                   pready, pslverr, cmdValid, cmdGrant, cmdDeny;
  logic                   sessionKeyEn, tunnelVariant;
  logic                   aes256Offer, aes128Offer, pwrCycleDone;
  logic [7:0]             paddr, sigmaFirstMsg;
  logic [31:0]            pwdata, prdata;
  logic [3:0]             pstrb;
  logic [1:0]             pinSetReq, pinClearReq, gpioOut, gpioOe;
  logic [1:0]             gpioI2cEn;
  pgob_pkg::pgob_cmd_type cmdKind;
  int                     n_errors, cmp_count;

  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  pgob_option_regs dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmdValid(cmdValid), .cmdKind(cmdKind),
    .sigmaFirstMsg(sigmaFirstMsg), .cmdGrant(cmdGrant),
    .cmdDeny(cmdDeny), .sessionKeyEn(sessionKeyEn),
    .tunnelVariant(tunnelVariant), .aes256Offer(aes256Offer),
    .aes128Offer(aes128Offer), .pinSetReq(pinSetReq),
    .pinClearReq(pinClearReq), .pwrCycleDone(pwrCycleDone),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioI2cEn(gpioI2cEn));

  pgob_host_model host (.clk_sys(clk_sys), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                        input logic xe);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  // one offered command, answer looked at in its single cycle
  task automatic cmd(input pgob_pkg::pgob_cmd_type k,
                     input logic [7:0] m, input logic g);
    @(posedge clk_sys);
    cmdValid      <= 1'b1;
    cmdKind       <= k;
    sigmaFirstMsg <= m;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    #1;
    chk({30'h0, cmdGrant, cmdDeny}, {30'h0, g, ~g});
  endtask

  task automatic pulse(input int w, input int p);
    @(posedge clk_sys);
    if (w == 0) pwrCycleDone <= 1'b1;
    if (w == 1) pinSetReq[p] <= 1'b1;
    if (w == 2) pinClearReq[p] <= 1'b1;
    @(posedge clk_sys);
    pwrCycleDone <= 1'b0;
    pinSetReq    <= 2'b00;
    pinClearReq  <= 2'b00;
    #1;
  endtask

  task automatic t_reset;
    chk({28'h0, sessionKeyEn, tunnelVariant, aes256Offer, aes128Offer},
        32'h3);
    rd_chk(pgob_pkg::OFFS_OPT_A, 32'h05, 1'b0);
    rd_chk(pgob_pkg::OFFS_OPT_B, 32'h1B, 1'b0);
    rd_chk(pgob_pkg::OFFS_CFG0, 32'h00, 1'b0);
    rd_chk(pgob_pkg::OFFS_CFG1, 32'h00, 1'b0);
    rd_chk(pgob_pkg::OFFS_FSEL, 32'h00, 1'b0);
  endtask

  task automatic t_opt_a;
    logic [7:0] v [5] = '{8'h00, 8'h80, 8'h04, 8'h01, 8'h85};
    foreach (v[i]) begin
      wr(pgob_pkg::OFFS_OPT_A, {24'h0, v[i]});
      @(posedge clk_sys);
      #1;
      chk({31'h0, sessionKeyEn}, {31'h0, v[i][7]});
      rd_chk(pgob_pkg::OFFS_OPT_A, {24'h0, v[i]}, 1'b0);
      cmd(pgob_pkg::CMD_ECC_UNI, 8'h00, v[i][2]);
      cmd(pgob_pkg::CMD_AES_FIRST, 8'h00, v[i][0]);
      cmd(pgob_pkg::CMD_AES_FOLLOW, 8'h00, v[i][0]);
    end
  endtask

  task automatic t_opt_b;
    logic [7:0] v [7] = '{8'h00, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
                          8'h1B};
    foreach (v[i]) begin
      wr(pgob_pkg::OFFS_OPT_B, {24'h0, v[i]});
      @(posedge clk_sys);
      #1;
      chk({31'h0, tunnelVariant}, {31'h0, v[i][2]});
      chk({31'h0, aes256Offer}, {31'h0, v[i][1]});
      chk({31'h0, aes128Offer}, {31'h0, v[i][0]});
      cmd(pgob_pkg::CMD_SIGMA, 8'hA0, v[i][4]);
      cmd(pgob_pkg::CMD_SIGMA, 8'hB0, v[i][3]);
      cmd(pgob_pkg::CMD_SIGMA, 8'h5A, 1'b0);
    end
    wr(pgob_pkg::OFFS_STAT, 32'h0);
    rd_chk(pgob_pkg::OFFS_STAT, 32'h80, 1'b0);
    cmd(pgob_pkg::CMD_SIGMA, 8'hA0, 1'b1);
    rd_chk(pgob_pkg::OFFS_STAT, 32'h40, 1'b0);
  endtask

  // every mode against every config value, on both pins
  task automatic t_gpio;
    logic [7:0] md [4] = '{8'h02, 8'h05, 8'h04, 8'h01};
    logic [1:0] cf, eo, ee, ei;
    logic       o, d;
    for (int p = 0; p < 2; p++) begin
      foreach (md[i]) begin
        for (int c = 0; c < 4; c++) begin
          cf = 2'(c);
          o  = (md[i] == 8'h02) || (md[i] == 8'h05);
          d  = (md[i] == 8'h04);
          eo = '0;
          ee = '0;
          ei = '0;
          eo[p] = o & cf[0];
          ee[p] = o;
          ei[p] = d & cf[1];
          wr(p ? pgob_pkg::OFFS_CFG1 : pgob_pkg::OFFS_CFG0, {30'h0, cf});
          wr(pgob_pkg::OFFS_FSEL, {24'h0, md[i]} << (8 * p));
          pulse(0, p);
          chk({30'h0, gpioOut}, {30'h0, eo});
          chk({30'h0, gpioOe}, {30'h0, ee});
          chk({30'h0, gpioI2cEn}, {30'h0, ei});
          eo[p] = o;
          pulse(1, p);
          chk({30'h0, gpioOut}, {30'h0, eo});
          pulse(2, p);
          chk({30'h0, gpioOut}, 32'h0);
        end
      end
      wr(pgob_pkg::OFFS_FSEL, 32'h0);
    end
  endtask

  initial begin
    n_errors      = 0;
    cmp_count     = 0;
    arst_n        = 1'b0;
    cmdValid      = 1'b0;
    cmdKind       = pgob_pkg::CMD_ECC_UNI;
    sigmaFirstMsg = 8'h00;
    pinSetReq     = 2'b00;
    pinClearReq   = 2'b00;
    pwrCycleDone  = 1'b0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset;
    t_opt_a;
    t_opt_b;
    t_gpio;
    rd_chk(8'h18, 32'h0, 1'b1);
    finish_test;
  end

  // run needs a few hundred cycles; allow ten thousand
  initial begin
    #50000;
    n_errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    finish_test;
  end
endmodule
